// [core/rail_sequencer.sv]
`timescale 1ns/10ps
// Functional notes
// - order 00: both rails stay off
// - 01 negative first, 10 positive first
// - order 11 starts both rails together
// - second rail waits for first near target
// - pin rise takes order from nonvolatile byte
// - switches off halts; clear restarts, selected order
// - discharge disabled: pin fall shuts down immediately
// - discharge: off, currents on, wait low, down
// - locked: nonvolatile config only, selects ignored
// - locked: config reads return nonvolatile bytes
// - locked programming: no change, fault set
// - lock is bit 6 of third byte
// - lock bit reads true nonvolatile state
// - programming ORs only selected volatile bytes into nonvolatile
// - select bit: run from volatile, mark byte
// - stop may follow program back to back
// - select bit picks read source per byte
// - fault cleared by reset or clear-fault write
module rail_sequencer
  import rail_seq_pkg::*;
#(
  parameter logic [2:0][7:0] NV_INIT = 24'h00_0000
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  shutdown_n_pin,
  input  wire logic                  pos_near,
  input  wire logic                  neg_near,
  input  wire logic                  pos_reg,
  input  wire logic                  neg_reg,
  input  wire logic                  pos_low,
  input  wire logic                  neg_low,
  input  wire logic                  vpp_ok,
  output logic                       pos_rail_en_r,
  output logic                       neg_rail_en_r,
  output logic                       ramp_hold_pos_r,
  output logic                       ramp_hold_neg_r,
  output logic                       discharge_en_r,
  output logic                       seq_done_r,
  output logic [7:0]                 pos_code_r,
  output logic [7:0]                 neg_code_r,
  output logic [1:0]                 ramp_current_r,
  output logic                       pos_fine_r
);

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  logic       rst_meta_r;
  logic       rst_n;
  logic [7:0] pins_s;
  logic       shutdown_n_pin_s, pos_near_s, neg_near_s, pos_reg_s, neg_reg_s;
  logic       pos_low_s, neg_low_s, vpp_ok_s;

  // reset enters asynchronously, released on the clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  pin_sync #(.W(8)) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({vpp_ok, neg_low, pos_low, neg_reg, pos_reg, neg_near, pos_near, shutdown_n_pin}),
    .q     (pins_s)
  );

  assign {vpp_ok_s, neg_low_s, pos_low_s, neg_reg_s, pos_reg_s, neg_near_s, pos_near_s, shutdown_n_pin_s} = pins_s;

  // ****************************************************************
  // configuration storage
  // ****************************************************************
  logic [2:0][7:0] vol_r;
  logic [2:0][7:0] nv_r;
  logic [2:0][7:0] act;
  logic [2:0]      sel_r;
  logic [2:0]      eff_sel;
  logic            locked;
  logic            prog_start_r;
  logic            switches_off_r;
  logic            fault_r;
  logic            prog_pulse;
  logic            prog_ok;

  assign locked  = nv_r[2][LOCK_BIT];
  assign eff_sel = locked ? SEL_RST : sel_r;

  // running configuration follows the select bits at once
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      act[i] = eff_sel[i] ? vol_r[i] : nv_r[i];
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic [AXI_ADDR_W-1:0] aw_addr_r;
  logic                  aw_hold_r, w_hold_r;
  logic [7:0]            w_byte_r;
  logic                  w_lane_r;
  logic                  wr_do, wr_hit, rd_take;
  logic [IDX_W-1:0]      wr_idx, rd_idx;
  logic                  wr_cmd;
  seq_state_t            state, state_nxt;

  function automatic logic reg_known(input logic [IDX_W-1:0] idx);
    reg_known = (idx == IDX_CFG0) || (idx == IDX_CFG1) || (idx == IDX_CFG2) ||
                (idx == IDX_CMD) || (idx == IDX_STAT);
  endfunction

  // read source per byte, lock bit always from the fuse copy
  function automatic logic [7:0] cfg_view(input int i);
    logic [7:0] v;
    v = eff_sel[i] ? vol_r[i] : nv_r[i];
    if (i == 2) begin
      v[LOCK_BIT] = locked;
    end
    cfg_view = v;
  endfunction

  assign wr_do   = aw_hold_r && w_hold_r && !bvalid;
  assign wr_idx  = aw_addr_r[AXI_ADDR_W-1:2];
  assign wr_hit  = reg_known(wr_idx);
  assign wr_cmd  = wr_do && w_lane_r && (wr_idx == IDX_CMD);
  assign rd_take = arvalid && arready;
  assign rd_idx  = araddr[AXI_ADDR_W-1:2];

  // write address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r  <= CFG_RST;
      w_lane_r  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_r <= awaddr;
        aw_hold_r <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_byte_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
        w_hold_r <= 1'b1;
        wready   <= 1'b0;
      end
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= reg_known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata   <= 32'h0000_0000;
      if (rd_idx == IDX_CFG0) begin
        rdata[7:0] <= cfg_view(0);
      end else if (rd_idx == IDX_CFG1) begin
        rdata[7:0] <= cfg_view(1);
      end else if (rd_idx == IDX_CFG2) begin
        rdata[7:0] <= cfg_view(2);
      end else if (rd_idx == IDX_CMD) begin
        rdata[7:0] <= {prog_start_r, fault_r, 1'b0, switches_off_r, 1'b0, sel_r};
      end else if (rd_idx == IDX_STAT) begin
        rdata[ST_SHUTDOWN_N_PIN]   <= shutdown_n_pin_s;
        rdata[ST_LOCKED] <= locked;
        rdata[ST_DONE]   <= seq_done_r;
        rdata[ST_POS_EN] <= pos_rail_en_r;
        rdata[ST_NEG_EN] <= neg_rail_en_r;
        rdata[ST_DISCH]  <= discharge_en_r;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ****************************************************************
  // volatile bytes and command register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vol_r <= '0;
    end else if (wr_do && w_lane_r) begin
      if (wr_idx == IDX_CFG0) begin
        vol_r[0] <= w_byte_r;
      end else if (wr_idx == IDX_CFG1) begin
        vol_r[1] <= w_byte_r;
      end else if (wr_idx == IDX_CFG2) begin
        vol_r[2] <= {1'b0, w_byte_r[RSVD2_BIT-1:0]};
      end
    end
  end

  // program starts on a rising start bit; stop may come next
  assign prog_pulse = wr_cmd && !w_byte_r[CMD_RST] && w_byte_r[CMD_PROG] && !prog_start_r;
  assign prog_ok    = prog_pulse && !locked && vpp_ok_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_start_r <= 1'b0;
      switches_off_r      <= 1'b0;
      sel_r        <= SEL_RST;
    end else if (wr_cmd) begin
      if (w_byte_r[CMD_RST]) begin
        prog_start_r <= 1'b0;
        switches_off_r      <= 1'b0;
        sel_r        <= SEL_RST;
      end else begin
        prog_start_r <= w_byte_r[CMD_PROG];
        switches_off_r      <= w_byte_r[CMD_SWITCHES_OFF];
        sel_r        <= w_byte_r[2:0];
      end
    end
  end

  // fault flag, a new fault wins over a clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (prog_pulse && !prog_ok) begin
      fault_r <= 1'b1;
    end else if (wr_cmd && (w_byte_r[CMD_CF] || w_byte_r[CMD_RST])) begin
      fault_r <= 1'b0;
    end
  end

  // fuse bytes only gain ones, selected bytes only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_r <= NV_INIT;
    end else if (prog_ok) begin
      for (int i = 0; i < 3; i++) begin
        if (sel_r[i]) begin
          nv_r[i] <= nv_r[i] | vol_r[i];
        end
      end
    end
  end

  // ****************************************************************
  // power sequencing
  // ****************************************************************
  logic [1:0]             order_r, order_nxt;
  logic                   disch_r;
  logic [START_CNT_W-1:0] wake_cnt_r;
  logic                   wake_done;

  function automatic seq_state_t dispatch(input logic [1:0] ord);
    if (ord == ORDER_OFF) begin
      dispatch = S_IDLE;
    end else if (ord == ORDER_BOTH) begin
      dispatch = S_SECOND;
    end else begin
      dispatch = S_FIRST;
    end
  endfunction

  assign wake_done = (wake_cnt_r == START_CNT_W'(START_DELAY_CYC - 1));

  // order source: fuse byte on pin rise, running byte on restart
  always_comb begin
    order_nxt = order_r;
    if (shutdown_n_pin_s && state == S_OFF) begin
      order_nxt = nv_r[2][ORDER_LSB +: 2];
    end else if (shutdown_n_pin_s && state == S_HALT && !switches_off_r) begin
      order_nxt = act[2][ORDER_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      order_r <= ORDER_OFF;
      disch_r <= 1'b0;
    end else begin
      order_r <= order_nxt;
      if (shutdown_n_pin_s && state == S_OFF) begin
        disch_r <= nv_r[2][DISCH_BIT];
      end else if (shutdown_n_pin_s && state == S_HALT && !switches_off_r) begin
        disch_r <= act[2][DISCH_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_r <= '0;
    end else if (state == S_WAKE) begin
      wake_cnt_r <= wake_cnt_r + 1'b1;
    end else begin
      wake_cnt_r <= '0;
    end
  end

  always_comb begin
    state_nxt = state;
    if (!shutdown_n_pin_s) begin
      if (state == S_DISCH) begin
        state_nxt = (pos_low_s && neg_low_s) ? S_OFF : S_DISCH;
      end else if (state != S_OFF) begin
        state_nxt = disch_r ? S_DISCH : S_OFF;
      end
    end else begin
      case (state)
        S_OFF:    state_nxt = S_WAKE;
        S_WAKE:   state_nxt = !wake_done ? S_WAKE : (switches_off_r ? S_HALT : dispatch(order_r));
        S_HALT:   state_nxt = switches_off_r ? S_HALT : dispatch(order_nxt);
        S_IDLE:   state_nxt = switches_off_r ? S_HALT : S_IDLE;
        S_FIRST: begin
          if (switches_off_r) begin
            state_nxt = S_HALT;
          end else if ((order_r == ORDER_NEG) ? neg_near_s : pos_near_s) begin
            state_nxt = S_SECOND;
          end
        end
        S_SECOND: state_nxt = switches_off_r ? S_HALT : ((pos_reg_s && neg_reg_s) ? S_REG : S_SECOND);
        S_REG:    state_nxt = switches_off_r ? S_HALT : S_REG;
        S_DISCH:  state_nxt = (pos_low_s && neg_low_s) ? S_OFF : S_DISCH;
        default:  state_nxt = S_OFF;
      endcase
    end
  end

  // state and the rail outputs move together
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= S_OFF;
      pos_rail_en_r   <= 1'b0;
      neg_rail_en_r   <= 1'b0;
      ramp_hold_pos_r <= 1'b1;
      ramp_hold_neg_r <= 1'b1;
      discharge_en_r  <= 1'b0;
      seq_done_r      <= 1'b0;
    end else begin
      state           <= state_nxt;
      pos_rail_en_r   <= (state_nxt == S_SECOND) || (state_nxt == S_REG) ||
                         (state_nxt == S_FIRST && order_nxt == ORDER_POS);
      neg_rail_en_r   <= (state_nxt == S_SECOND) || (state_nxt == S_REG) ||
                         (state_nxt == S_FIRST && order_nxt == ORDER_NEG);
      ramp_hold_pos_r <= !((state_nxt == S_SECOND) || (state_nxt == S_REG) ||
                           (state_nxt == S_FIRST && order_nxt == ORDER_POS));
      ramp_hold_neg_r <= !((state_nxt == S_SECOND) || (state_nxt == S_REG) ||
                           (state_nxt == S_FIRST && order_nxt == ORDER_NEG));
      discharge_en_r  <= (state_nxt == S_DISCH);
      seq_done_r      <= (state_nxt == S_REG);
    end
  end

  // analog trim codes from the running configuration
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_code_r     <= CFG_RST;
      neg_code_r     <= CFG_RST;
      ramp_current_r <= 2'h0;
      pos_fine_r     <= 1'b0;
    end else begin
      pos_code_r     <= act[0];
      neg_code_r     <= act[1];
      ramp_current_r <= act[2][IRMP_LSB +: 2];
      pos_fine_r     <= act[2][VPLUS_BIT];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_order_zero_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == S_IDLE) |-> (!pos_rail_en_r && !neg_rail_en_r)) else $error("rails on with order 00");

  a_neg_first_only: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == S_FIRST && order_r == ORDER_NEG) |-> (neg_rail_en_r && !pos_rail_en_r))
    else $error("negative-first order broken");

  a_both_start_same: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ($rose(pos_rail_en_r) && order_r == ORDER_BOTH) |-> $rose(neg_rail_en_r))
    else $error("rails did not start together");

  a_second_waits_near: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == S_FIRST && order_r == ORDER_POS && !pos_near_s && shutdown_n_pin_s && !switches_off_r) |=> !neg_rail_en_r)
    else $error("second rail started early");

  a_wake_uses_fuse: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == S_OFF && shutdown_n_pin_s) |=> (state == S_WAKE && order_r == $past(nv_r[2][1:0])))
    else $error("wake order not from fuse byte");

  a_switches_off_halts: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    switches_off_r |=> (!pos_rail_en_r && !neg_rail_en_r)) else $error("switches off did not stop rails");

  a_fast_shutdown: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ($fell(shutdown_n_pin_s) && !disch_r) |=> (state == S_OFF && !discharge_en_r))
    else $error("no immediate shutdown");

  a_discharge_waits: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == S_DISCH && !shutdown_n_pin_s && !(pos_low_s && neg_low_s)) |=> (discharge_en_r && state == S_DISCH))
    else $error("discharge ended early");

  a_locked_no_prog: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (prog_pulse && locked) |=> (fault_r && nv_r == $past(nv_r)))
    else $error("locked fuse changed or no fault");

  a_locked_read_nv: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rd_take && locked && rd_idx == IDX_CFG1) |=> (rdata[7:0] == nv_r[1]))
    else $error("locked read not from fuse");

endmodule

// [core/rail_seq_pkg.sv]
package rail_seq_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int AXI_ADDR_W = 8;
  localparam int IDX_W      = AXI_ADDR_W - 2;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CFG0 = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CFG1 = 6'h01;
  localparam logic [IDX_W-1:0] IDX_CFG2 = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CMD  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_STAT = 6'h05;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ORDER_LSB  = 0;
  localparam int DISCH_BIT  = 2;
  localparam int IRMP_LSB   = 3;
  localparam int VPLUS_BIT  = 5;
  localparam int LOCK_BIT   = 6;
  localparam int RSVD2_BIT  = 7;

  localparam int CMD_PROG   = 7;
  localparam int CMD_CF     = 6;
  localparam int CMD_RST    = 5;
  localparam int CMD_SWITCHES_OFF  = 4;

  localparam int ST_SHUTDOWN_N_PIN    = 0;
  localparam int ST_LOCKED  = 1;
  localparam int ST_DONE    = 2;
  localparam int ST_POS_EN  = 3;
  localparam int ST_NEG_EN  = 4;
  localparam int ST_DISCH   = 5;

  // power-up order codes
  localparam logic [1:0] ORDER_OFF  = 2'h0;
  localparam logic [1:0] ORDER_NEG  = 2'h1;
  localparam logic [1:0] ORDER_POS  = 2'h2;
  localparam logic [1:0] ORDER_BOTH = 2'h3;

  // reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [2:0] SEL_RST = 3'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int START_DELAY_NS  = 64000;
  localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CNT_W     = 10;

  typedef enum {
    S_OFF, S_WAKE, S_HALT, S_IDLE, S_FIRST, S_SECOND, S_REG, S_DISCH
  } seq_state_t;

endpackage

// [core/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// [verification/rail_model.sv]
`timescale 1ns/10ps
module rail_model (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic en,
  input  wire logic dis,
  output logic      near,
  output logic      reg_ok,
  output logic      low
);
  logic [4:0] lvl_r;

  // output level: ramps while on, drops to 6 when off, then drains only under discharge current
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_r <= 5'h00;
    end else if (en) begin
      lvl_r <= lvl_r + {4'h0, lvl_r != 5'h1f};
    end else if (lvl_r > 5'h06) begin
      lvl_r <= 5'h06;
    end else if (dis && lvl_r != 5'h00) begin
      lvl_r <= lvl_r - 5'h01;
    end
  end

  // level flags seen by the sequencer
  assign near   = en && lvl_r >= 5'h0c;
  assign reg_ok = en && lvl_r >= 5'h14;
  assign low    = lvl_r < 5'h02;
endmodule

// [verification/rail_sequencer_test.sv]
`timescale 1ns/10ps
module rail_sequencer_test;
  import rail_seq_pkg::*;
  logic        ref_clk, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic        arready, rvalid, shutdown_n_pin, vpp_ok, pos_near, neg_near, pos_reg, neg_reg;
  logic        pos_low, neg_low, pos_rail_en_r, neg_rail_en_r, discharge_en_r, seq_done_r;
  logic        ramp_hold_pos_r, ramp_hold_neg_r, pos_fine_r;
  logic [7:0]  awaddr, araddr, cmd_v, pos_code_r, neg_code_r;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, ramp_current_r;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // ********
  // design and rail models
  // ********
  rail_sequencer #(.NV_INIT(24'h02_0000)) i_dut (
    .ref_clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .shutdown_n_pin,
    .pos_near, .neg_near, .pos_reg, .neg_reg, .pos_low, .neg_low, .vpp_ok, .pos_rail_en_r,
    .neg_rail_en_r, .ramp_hold_pos_r, .ramp_hold_neg_r, .discharge_en_r, .seq_done_r,
    .pos_code_r, .neg_code_r, .ramp_current_r, .pos_fine_r
  );
  rail_model i_pos (.ref_clk, .arst_n, .en(pos_rail_en_r), .dis(discharge_en_r), .near(pos_near),
                    .reg_ok(pos_reg), .low(pos_low));
  rail_model i_neg (.ref_clk, .arst_n, .en(neg_rail_en_r), .dis(discharge_en_r), .near(neg_near),
                    .reg_ok(neg_reg), .low(neg_low));

  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ********
  // tasks
  // ********
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", er, bresp);
    @(posedge ref_clk);
  endtask

  // bus read, masked compare
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk("rresp", RESP_OKAY, rresp);
    chk(nm, e, rdata & m);
    @(posedge ref_clk);
  endtask

  task automatic pin_up();
    shutdown_n_pin <= 1'b1;
    while (!(pos_rail_en_r || neg_rail_en_r)) @(posedge ref_clk);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, shutdown_n_pin, vpp_ok} = '0;
    {awaddr, araddr, wdata} = '0;
    arst_n = 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(3);
    wr(8'h08, 8'h39);
    wr(8'h10, 8'h04);
    chk("cfg2 run", 32'h7, {ramp_current_r, pos_fine_r});
    pin_up();
    chk("first rail", 32'h2, {pos_rail_en_r, neg_rail_en_r});
    cyc(60);
    chk("done", 32'h1, seq_done_r);
    for (int o = 0; o < 4; o++) begin
      wr(8'h08, 8'(o));
      wr(8'h10, 8'h14);
      cyc(2);
      chk("halted", 32'h3, {pos_rail_en_r, neg_rail_en_r, ramp_hold_pos_r, ramp_hold_neg_r});
      wr(8'h10, 8'h04);
      cyc(4);
      chk("order", o, {pos_rail_en_r, neg_rail_en_r});
      cyc(60);
      chk("rails", (o != 0) ? 3 : 0, {pos_rail_en_r, neg_rail_en_r});
    end
    rc(8'h08, 32'hff, 32'h03, "cfg2 vol");
    wr(8'h10, 8'h00);
    rc(8'h08, 32'hff, 32'h02, "cfg2 nv");
    shutdown_n_pin <= 1'b0;
    cyc(4);
    chk("off", 32'h0, {pos_rail_en_r, neg_rail_en_r, discharge_en_r});
    vpp_ok <= 1'b1;
    wr(8'h10, 8'h50);
    wr(8'h00, 8'ha5);
    wr(8'h04, 8'h3c);
    wr(8'h08, 8'h07);
    for (int b = 0; b < 3; b += 2) begin
      cmd_v = 8'h10 | (8'h01 << b);
      wr(8'h10, cmd_v);
      wr(8'h10, cmd_v | 8'h80);
      wr(8'h10, cmd_v);
      rc(8'h10, 32'h40, 32'h0, "fault");
    end
    wr(8'h10, 8'h10);
    rc(8'h00, 32'hff, 32'ha5, "cfg0 nv");
    rc(8'h04, 32'hff, 32'h00, "cfg1 nv");
    wr(8'h10, 8'h00);
    pin_up();
    chk("both", 32'h3, {pos_rail_en_r, neg_rail_en_r});
    cyc(60);
    shutdown_n_pin <= 1'b0;
    cyc(4);
    chk("disch on", 32'h1, {pos_rail_en_r, neg_rail_en_r, discharge_en_r});
    cyc(30);
    chk("disch off", 32'h0, discharge_en_r);
    wr(8'h08, 8'h40);
    wr(8'h10, 8'h14);
    wr(8'h10, 8'h94);
    wr(8'h10, 8'h14);
    rc(8'h14, 32'h2, 32'h2, "locked");
    rc(8'h08, 32'hff, 32'h47, "cfg2 lock");
    wr(8'h00, 8'hff);
    wr(8'h10, 8'h13);
    wr(8'h10, 8'h93);
    rc(8'h10, 32'h40, 32'h40, "fault");
    rc(8'h00, 32'hff, 32'ha5, "cfg0 lock");
    rc(8'h04, 32'hff, 32'h00, "cfg1 lock");
    chk("codes", 32'ha500, {pos_code_r, neg_code_r});
    wr(8'h10, 8'h51);
    rc(8'h10, 32'h40, 32'h0, "fault clr");
    wr(8'h0c, 8'h00, RESP_SLVERR);
    finish_test();
  end
endmodule
